// >>> rtl/strap_mode_decode.sv
// strap capture, mode decode and request/grant pin reassignment
//
// Behaviour
// - test strap low normal, high test functions
// - side select 0 eeprom master, 1 smbus
// - bridging type 0 transparent, 1 non-transparent
// - direction strap 0 forward, 1 reverse
// - arbiter select low internal, high external
// - external arbiter: request0 grant in, grant0 request
// - external arbiter: request/grant 5:2 become gpio
// - clock mask strap high enables hot-plug
// - arbiter select has weak internal pull-down
// - reverse mode reassigns request0 like external arbiter
// - eeprom mode drives side-channel clock out
`timescale 1ns/1ns
`default_nettype none
module strap_mode_decode (
  // clock and reset
  input  wire logic                           aclk,
  input  wire logic                           aresetn,
  // strap pins
  input  wire logic                           test_mode_strap,
  input  wire logic                           side_channel_select,
  input  wire logic                           bridging_type_select,
  input  wire logic                           bridge_direction_select,
  input  wire logic                           arbiter_select_n,
  input  wire logic                           clock_mask_strap,
  // request / grant pins, active low
  input  wire logic [strap_pkg::REQ_W-1:0]    req_pin_n,
  output var  logic [strap_pkg::REQ_W-1:0]    gnt_pin_n,
  // internal arbiter and bridge core side
  input  wire logic [strap_pkg::REQ_W-1:0]    arb_gnt_n,
  output var  logic [strap_pkg::REQ_W-1:0]    arb_req_n,
  input  wire logic                           core_bus_req_n,
  output var  logic                           core_bus_gnt_n,
  output var  logic [strap_pkg::GP_W-1:0]     general_inputs,
  // decoded modes
  output var  logic                           test_enable,
  output var  logic                           smbus_slave_en,
  output var  logic                           non_transparent,
  output var  logic                           reverse_mode,
  output var  logic                           internal_arb_en,
  output var  logic                           hot_plug_en,
  output var  logic                           scl_drive_en,
  output var  logic                           arb_sel_pull_down,
  // axi4-lite slave
  input  wire logic [strap_pkg::ADDR_W-1:0]   awaddr,
  input  wire logic                           awvalid,
  output var  logic                           awready,
  input  wire logic [31:0]                    wdata,
  input  wire logic [3:0]                     wstrb,
  input  wire logic                           wvalid,
  output var  logic                           wready,
  output var  logic [1:0]                     bresp,
  output var  logic                           bvalid,
  input  wire logic                           bready,
  input  wire logic [strap_pkg::ADDR_W-1:0]   araddr,
  input  wire logic                           arvalid,
  output var  logic                           arready,
  output var  logic [31:0]                    rdata,
  output var  logic [1:0]                     rresp,
  output var  logic                           rvalid,
  input  wire logic                           rready
);
  // ****************************************
  // declarations
  // ****************************************
  logic [strap_pkg::STRAP_W-1:0] strap_s;     // synchronised straps
  logic [strap_pkg::REQ_W-1:0]   req_s_n;     // synchronised request pins
  logic [strap_pkg::STRAP_W-1:0] strap_ff;    // captured straps
  logic                          captured_ff; // capture done since reset
  logic                          ext_mux;     // request0/grant0 reassigned
  logic [strap_pkg::GP_W-1:0]    gpo_ff;      // general output register
  logic [strap_pkg::ADDR_W-1:0]  awaddr_ff;   // latched write address
  logic [31:0]                   wdata_ff;    // latched write data
  logic [3:0]                    wstrb_ff;    // latched strobes
  logic                          aw_got_ff;   // write address held
  logic                          w_got_ff;    // write data held

  // register decode shared by read and write paths
  function automatic logic is_mapped(input logic [strap_pkg::ADDR_W-1:0] a);
    is_mapped = (a == strap_pkg::OFF_MODE) || (a == strap_pkg::OFF_GPO) ||
                (a == strap_pkg::OFF_GPI);
  endfunction : is_mapped

  // ****************************************
  // pin synchronisers
  // ****************************************
  strap_sync #(.W(strap_pkg::STRAP_W)) u_strap_sync (
    .aclk (aclk),
    .d    ({clock_mask_strap, arbiter_select_n, bridge_direction_select,
            bridging_type_select, side_channel_select, test_mode_strap}),
    .q    (strap_s)
  );
  strap_sync #(.W(strap_pkg::REQ_W)) u_req_sync (
    .aclk (aclk),
    .d    (req_pin_n),
    .q    (req_s_n)
  );

  // ****************************************
  // strap capture
  // ****************************************
  // one capture at the first edge after release; a strap that moves later
  // is ignored, so a bouncing board cannot change modes under traffic
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      captured_ff <= 1'b0;
      strap_ff    <= '0;
    end else if (!captured_ff) begin
      captured_ff <= 1'b1;
      strap_ff    <= strap_s;
    end
  end

  // reverse mode reassigns request0/grant0 just like an external arbiter
  assign ext_mux = strap_ff[strap_pkg::S_ARB] | strap_ff[strap_pkg::S_REV];

  // ****************************************
  // decoded mode outputs
  // ****************************************
  // all modes except the select pull-down stay inactive until the capture has happened
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      test_enable       <= 1'b0;
      smbus_slave_en    <= 1'b0;
      non_transparent   <= 1'b0;
      reverse_mode      <= 1'b0;
      internal_arb_en   <= 1'b0;
      hot_plug_en       <= 1'b0;
      scl_drive_en      <= 1'b0;
      arb_sel_pull_down <= 1'b1;
    end else begin
      test_enable       <= captured_ff & strap_ff[strap_pkg::S_TEST];
      smbus_slave_en    <= captured_ff & strap_ff[strap_pkg::S_SIDE];
      non_transparent   <= captured_ff & strap_ff[strap_pkg::S_NTB];
      reverse_mode      <= captured_ff & strap_ff[strap_pkg::S_REV];
      internal_arb_en   <= captured_ff & ~strap_ff[strap_pkg::S_ARB];
      hot_plug_en       <= captured_ff & strap_ff[strap_pkg::S_HP];
      scl_drive_en      <= captured_ff & ~strap_ff[strap_pkg::S_SIDE];
      arb_sel_pull_down <= 1'b1;  // pad pull-down always on
    end
  end

  // ****************************************
  // request / grant pin reassignment
  // ****************************************
  // line 1 has no use in the reassigned map and is held deasserted
  always_ff @(posedge aclk) begin
    if (!aresetn || !captured_ff) begin
      gnt_pin_n      <= '1;
      arb_req_n      <= '1;
      core_bus_gnt_n <= 1'b1;
      general_inputs <= '0;
    end else if (ext_mux) begin
      gnt_pin_n[0]   <= core_bus_req_n;
      gnt_pin_n[1]   <= 1'b1;
      core_bus_gnt_n <= req_s_n[0];
      arb_req_n      <= '1;
      if (strap_ff[strap_pkg::S_ARB]) begin
        gnt_pin_n[strap_pkg::REQ_W-1:strap_pkg::GP_LO] <= gpo_ff;
        general_inputs <= req_s_n[strap_pkg::REQ_W-1:strap_pkg::GP_LO];
      end else begin
        // reverse only: lines 5:2 stay idle, inputs read as zero
        gnt_pin_n[strap_pkg::REQ_W-1:strap_pkg::GP_LO] <= '1;
        general_inputs <= '0;
      end
    end else begin
      gnt_pin_n      <= arb_gnt_n;   // internal arbiter owns the pins
      arb_req_n      <= req_s_n;
      core_bus_gnt_n <= 1'b1;
      general_inputs <= '0;
    end
  end

  // ****************************************
  // axi4-lite write path
  // ****************************************
  // address and data taken in either order; response after both
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_ff <= 1'b0;
      w_got_ff  <= 1'b0;
      awaddr_ff <= '0;
      wdata_ff  <= '0;
      wstrb_ff  <= '0;
      awready   <= 1'b0;
      wready    <= 1'b0;
      bvalid    <= 1'b0;
      bresp     <= strap_pkg::RESP_OK;
      gpo_ff    <= strap_pkg::GPO_RST;
    end else begin
      awready <= !aw_got_ff && !(awvalid && awready) && !bvalid;
      wready  <= !w_got_ff && !(wvalid && wready) && !bvalid;
      if (awvalid && awready) begin
        aw_got_ff <= 1'b1;
        awaddr_ff <= awaddr;
      end
      if (wvalid && wready) begin
        w_got_ff <= 1'b1;
        wdata_ff <= wdata;
        wstrb_ff <= wstrb;
      end
      if (aw_got_ff && w_got_ff && !bvalid) begin
        aw_got_ff <= 1'b0;
        w_got_ff  <= 1'b0;
        bvalid    <= 1'b1;
        bresp     <= is_mapped(awaddr_ff) ? strap_pkg::RESP_OK : strap_pkg::RESP_ERR;
        // only the low lane carries writable bits
        if (awaddr_ff == strap_pkg::OFF_GPO && wstrb_ff[0]) begin
          gpo_ff <= wdata_ff[strap_pkg::GP_W-1:0];
        end
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  // ****************************************
  // axi4-lite read path
  // ****************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b0;
      rvalid  <= 1'b0;
      rdata   <= '0;
      rresp   <= strap_pkg::RESP_OK;
    end else begin
      arready <= !rvalid && !(arvalid && arready);
      if (arvalid && arready) begin
        rvalid <= 1'b1;
        rresp  <= is_mapped(araddr) ? strap_pkg::RESP_OK : strap_pkg::RESP_ERR;
        case (araddr)
          strap_pkg::OFF_MODE: rdata <= {25'h0000000, captured_ff,
                                         strap_ff[strap_pkg::S_HP],
                                         ~strap_ff[strap_pkg::S_ARB],
                                         strap_ff[strap_pkg::S_REV],
                                         strap_ff[strap_pkg::S_NTB],
                                         strap_ff[strap_pkg::S_SIDE],
                                         strap_ff[strap_pkg::S_TEST]};
          strap_pkg::OFF_GPO:  rdata <= {28'h0000000, gpo_ff};
          strap_pkg::OFF_GPI:  rdata <= {28'h0000000, general_inputs};
          default:             rdata <= 32'h00000000;
        endcase
      end else if (rvalid && rready) begin
        rvalid <= 1'b0;
      end
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_modes_held: assert property (captured_ff && $past(captured_ff) |-> $stable(strap_ff))
    else $error("captured straps changed after capture");
  a_test_follows: assert property (captured_ff |=> test_enable == strap_ff[strap_pkg::S_TEST])
    else $error("test enable does not follow strap");
  a_side_channel: assert property (captured_ff |=> smbus_slave_en != scl_drive_en)
    else $error("side channel mode not exclusive");
  a_bridge_type: assert property (captured_ff |=> non_transparent == strap_ff[strap_pkg::S_NTB])
    else $error("bridging type mismatch");
  a_direction: assert property (captured_ff |=> reverse_mode == strap_ff[strap_pkg::S_REV])
    else $error("direction mode mismatch");
  a_int_arb: assert property (captured_ff && !ext_mux |=> gnt_pin_n == $past(arb_gnt_n))
    else $error("internal arbiter grants not on pins");
  a_grant_in: assert property (captured_ff && ext_mux |=> core_bus_gnt_n == $past(req_s_n[0]))
    else $error("request0 not routed as grant input");
  a_request_out: assert property (captured_ff && ext_mux |=> gnt_pin_n[0] == $past(core_bus_req_n))
    else $error("grant0 not driven by bus request");
  a_gpio_map: assert property (captured_ff && strap_ff[strap_pkg::S_ARB]
      |=> gnt_pin_n[5:2] == $past(gpo_ff) && general_inputs == $past(req_s_n[5:2]))
    else $error("general purpose mapping wrong");
  a_hot_plug: assert property (captured_ff |=> hot_plug_en == strap_ff[strap_pkg::S_HP])
    else $error("hot plug enable mismatch");
  a_pull_down: assert property (##1 arb_sel_pull_down)
    else $error("arbiter select pull-down released");
  a_scl_drive: assert property (captured_ff |=> scl_drive_en == !strap_ff[strap_pkg::S_SIDE])
    else $error("scl drive wrong for side channel mode");

  c_ext_arb: cover property (captured_ff && strap_ff[strap_pkg::S_ARB]);
  c_reverse: cover property (captured_ff && strap_ff[strap_pkg::S_REV]);
  c_write:   cover property (bvalid && bready && bresp == strap_pkg::RESP_OK);
  c_read:    cover property (rvalid && rready);
endmodule : strap_mode_decode
`default_nettype wire

// >>> pkg/strap_pkg.sv
// constants for the strap decode and pin reassignment block
`default_nettype none
package strap_pkg;
  // ****************************************
  // pin group widths
  // ****************************************
  localparam int unsigned REQ_W    = 6;   // request / grant line count
  localparam int unsigned GP_W     = 4;   // general purpose in / out width
  localparam int unsigned GP_LO    = 2;   // lowest request line reused as input
  localparam int unsigned STRAP_W  = 6;   // number of strap pins
  // ****************************************
  // strap vector bit positions
  // ****************************************
  localparam int unsigned S_TEST   = 0;   // test mode strap
  localparam int unsigned S_SIDE   = 1;   // side channel select
  localparam int unsigned S_NTB    = 2;   // bridging type select
  localparam int unsigned S_REV    = 3;   // bridge direction select
  localparam int unsigned S_ARB    = 4;   // arbiter select, active low pin
  localparam int unsigned S_HP     = 5;   // clock mask strap
  // ****************************************
  // register map, byte addresses
  // ****************************************
  localparam int unsigned ADDR_W   = 4;
  localparam logic [3:0]  OFF_MODE = 4'h0;  // decoded modes, read only
  localparam logic [3:0]  OFF_GPO  = 4'h4;  // general outputs, read/write
  localparam logic [3:0]  OFF_GPI  = 4'h8;  // general inputs, read only
  localparam int unsigned M_CAP    = 6;     // mode register: straps captured
  localparam logic [3:0]  GPO_RST  = 4'h0;
  // ****************************************
  // bus responses
  // ****************************************
  localparam logic [1:0]  RESP_OK  = 2'h0;
  localparam logic [1:0]  RESP_ERR = 2'h2;
endpackage : strap_pkg
`default_nettype wire

// >>> rtl/strap_sync.sv
// two flip-flop synchroniser for a group of asynchronous pin levels
`timescale 1ns/1ns
`default_nettype none
module strap_sync #(
  parameter int unsigned W = 1
) (
  // clock
  input  wire logic         aclk,
  // pin side and synchronised side
  input  wire logic [W-1:0] d,
  output var  logic [W-1:0] q
);
  logic [W-1:0] meta_ff;  // first stage, read only by the second

  // no reset: levels flow during reset so they are settled at release
  always_ff @(posedge aclk) begin
    meta_ff <= d;
    q       <= meta_ff;
  end
endmodule : strap_sync
`default_nettype wire

// >>> testbench/strap_board.sv
// board strap resistors and external bus arbiter facing the strap decode block
`timescale 1ns/1ns
`default_nettype none
module strap_board (
  // clock
  input  wire logic       aclk,
  // bench controls
  input  wire logic [5:0] cfg,
  input  wire logic       arb_open,
  input  wire logic [5:0] req_drv_n,
  input  wire logic       slow,
  // device side
  input  wire logic       pull_down,
  input  wire logic       bus_req_n,
  output var  logic [5:0] straps,
  output var  logic [5:0] req_pin_n
);
  logic [2:0] gnt_dly_ff;        // grant pipeline of the arbiter
  logic       last_ff = 1'b0;    // last level seen on the select pin
  logic       mux;               // line 0 belongs to the arbiter
  // open select pin: pull-down wins, otherwise a toggling level
  always_comb begin
    straps = cfg;
    if (arb_open) begin
      straps[strap_pkg::S_ARB] = pull_down ? 1'b0 : ~last_ff;
    end
  end
  // arbiter grants what is requested, promptly or slowly
  always_ff @(posedge aclk) begin
    last_ff    <= straps[strap_pkg::S_ARB];
    gnt_dly_ff <= {gnt_dly_ff[1:0], bus_req_n};
  end
  assign mux = straps[strap_pkg::S_ARB] | cfg[strap_pkg::S_REV];
  assign req_pin_n = {req_drv_n[5:1],
                      mux ? (slow ? gnt_dly_ff[2] : gnt_dly_ff[0]) : req_drv_n[0]};
endmodule : strap_board
`default_nettype wire

// >>> testbench/strap_mode_decode_bench.sv
// self-checking bench for the strap decode and pin reassignment block
`timescale 1ns/1ns
`default_nettype none
module strap_mode_decode_bench;
  // ****************************************
  // stimulus and observed signals
  // ****************************************
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [5:0]  cfg = 6'h00;          // board strap pattern
  logic        arb_open = 1'b0;      // select pin left open
  logic [5:0]  req_drv_n = 6'h3F;
  logic [5:0]  arb_gnt_n = 6'h3F;
  logic        core_bus_req_n = 1'b1;
  logic        slow = 1'b0;
  logic [3:0]  awaddr = 4'h0, araddr = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic [3:0]  wstrb = 4'hF;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid, core_bus_gnt_n;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  logic [5:0]  straps, req_pin_n, gnt_pin_n, arb_req_n;
  logic [3:0]  general_inputs;
  logic [7:0]  modes;                // all decoded mode levels
  logic        t_en, smb, ntb, rev, iarb, hp, scl, pd;
  int          miscompares = 0, checks = 0, cycles = 0;
  assign modes = {scl, hp, iarb, rev, ntb, smb, t_en, pd};
  always #2 aclk = ~aclk;            // 4 ns period
  // ****************************************
  // instances
  // ****************************************
  strap_board board (.aclk(aclk), .cfg(cfg), .arb_open(arb_open), .req_drv_n(req_drv_n),
    .slow(slow), .pull_down(pd), .bus_req_n(gnt_pin_n[0]), .straps(straps),
    .req_pin_n(req_pin_n));
  strap_mode_decode dut (.aclk(aclk), .aresetn(aresetn),
    .test_mode_strap(straps[strap_pkg::S_TEST]), .side_channel_select(straps[strap_pkg::S_SIDE]),
    .bridging_type_select(straps[strap_pkg::S_NTB]),
    .bridge_direction_select(straps[strap_pkg::S_REV]),
    .arbiter_select_n(straps[strap_pkg::S_ARB]), .clock_mask_strap(straps[strap_pkg::S_HP]),
    .req_pin_n(req_pin_n), .gnt_pin_n(gnt_pin_n), .arb_gnt_n(arb_gnt_n), .arb_req_n(arb_req_n),
    .core_bus_req_n(core_bus_req_n), .core_bus_gnt_n(core_bus_gnt_n),
    .general_inputs(general_inputs), .test_enable(t_en), .smbus_slave_en(smb),
    .non_transparent(ntb), .reverse_mode(rev), .internal_arb_en(iarb), .hot_plug_en(hp),
    .scl_drive_en(scl), .arb_sel_pull_down(pd), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));
  // ****************************************
  // tasks
  // ****************************************
  task automatic stop_test();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : stop_test
  task automatic cmp_reg(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : cmp_reg
  task automatic cmp_pin(input logic [7:0] got, input logic [7:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : cmp_pin
  // write: address and data offered together, each dropped when taken
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw_pend, w_pend, b_pend;  // channels still waiting for their handshake
    // one edge apart from the last transfer: no signal is driven twice in a step
    @(posedge aclk);
    aw_pend = 1'b1;
    w_pend  = 1'b1;
    b_pend  = 1'b1;
    awaddr <= a; awvalid <= 1'b1; wdata <= d; wvalid <= 1'b1; bready <= 1'b1;
    // pending flags, not the driven signals: those only update after this step
    while (aw_pend || w_pend || b_pend) begin
      @(posedge aclk);
      if (aw_pend && awready) begin aw_pend = 1'b0; awvalid <= 1'b0; end
      if (w_pend && wready) begin w_pend = 1'b0; wvalid <= 1'b0; end
      if (b_pend && bvalid) begin r = bresp; b_pend = 1'b0; bready <= 1'b0; end
    end
  endtask : axi_wr
  task automatic axi_rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ar_pend, r_pend;  // channels still waiting for their handshake
    @(posedge aclk);
    ar_pend = 1'b1;
    r_pend  = 1'b1;
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    while (ar_pend || r_pend) begin
      @(posedge aclk);
      if (ar_pend && arready) begin ar_pend = 1'b0; arvalid <= 1'b0; end
      if (r_pend && rvalid) begin d = rdata; r = rresp; r_pend = 1'b0; rready <= 1'b0; end
    end
  endtask : axi_rd
  // hang guard, well above the expected run length
  always @(posedge aclk) begin
    cycles++;
    if (cycles == 6000) begin miscompares++; stop_test(); end
  end
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    logic [31:0] d, w;
    logic [1:0]  r;
    logic [5:0]  e, gexp;
    logic        mux, ext;
    void'($urandom(32'h25D8));
    for (int t = 0; t < 10; t++) begin
      // one strap bit per run, then all-low with open select, then random
      cfg <= (t < 6) ? 6'h01 << t : ((t == 6) ? 6'h00 : 6'($urandom));
      arb_open <= (t == 6) || (t == 9);
      slow <= t[0];
      aresetn <= 1'b0;
      repeat (12) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (3) @(posedge aclk);
      e = arb_open ? cfg & ~(6'h01 << strap_pkg::S_ARB) : cfg;
      ext = e[strap_pkg::S_ARB];
      mux = ext | e[strap_pkg::S_REV];
      cmp_pin(modes, {~e[1], e[5], ~e[4], e[3], e[2], e[1], e[0], 1'b1}, "modes");
      axi_rd(strap_pkg::OFF_MODE, d, r);
      // mode word bit 4 reads back the internal arbiter enable, not the pin level
      cmp_reg(d, 32'h40 | {26'h0, e ^ 6'h10}, "mode word");
      axi_rd(strap_pkg::OFF_GPO, d, r);
      cmp_reg(d, 32'h0, "output word after reset");
      w = $urandom;
      arb_gnt_n <= 6'($urandom);
      req_drv_n <= 6'($urandom);
      core_bus_req_n <= 1'($urandom);
      axi_wr(strap_pkg::OFF_GPO, w, r);
      cmp_reg({30'h0, r}, {30'h0, strap_pkg::RESP_OK}, "output write resp");
      axi_rd(strap_pkg::OFF_GPO, d, r);
      cmp_reg(d, {28'h0, w[3:0]}, "output word");
      repeat (12) @(posedge aclk);
      gexp = mux ? {ext ? w[3:0] : 4'hF, 1'b1, core_bus_req_n} : arb_gnt_n;
      cmp_pin({2'h0, gnt_pin_n}, {2'h0, gexp}, "grant pins");
      cmp_pin({2'h0, arb_req_n}, mux ? 8'h3F : {2'h0, req_drv_n}, "arbiter requests");
      cmp_pin({7'h0, core_bus_gnt_n}, {7'h0, mux ? core_bus_req_n : 1'b1}, "core grant");
      cmp_pin({4'h0, general_inputs}, {4'h0, ext ? req_drv_n[5:2] : 4'h0}, "gen inputs");
      axi_rd(4'hC, d, r);
      cmp_reg({r, d[29:0]}, {strap_pkg::RESP_ERR, 30'h0}, "unmapped read");
      axi_wr(4'hC, w, r);
      cmp_reg({30'h0, r}, {30'h0, strap_pkg::RESP_ERR}, "unmapped write");
      axi_wr(strap_pkg::OFF_MODE, ~w, r);
      cmp_reg({30'h0, r}, {30'h0, strap_pkg::RESP_OK}, "mode write resp");
      // only the read-only write of ~w can show a change to the outputs; the unmapped write repeats w
      axi_rd(strap_pkg::OFF_GPO, d, r);
      cmp_reg(d, {28'h0, w[3:0]}, "output word kept");
      // straps move after capture: decoded modes must not follow
      cfg <= ~cfg;
      arb_open <= 1'b0;
      repeat (8) @(posedge aclk);
      cmp_pin(modes, {~e[1], e[5], ~e[4], e[3], e[2], e[1], e[0], 1'b1}, "held modes");
      axi_rd(strap_pkg::OFF_MODE, d, r);
      cmp_reg(d, 32'h40 | {26'h0, e ^ 6'h10}, "held mode word");
    end
    stop_test();
  end
endmodule : strap_mode_decode_bench
`default_nettype wire
